// *** core/uiorb_regs.sv ***
// register front end of a two-channel uart reached through i/o space
// assumes: io strobes come from the bus decode on clk_in, already qualified
// by the first base address hit; line-side status comes from the channel
// cores on the same clock, so nothing here is synchronised
//
// Summary of operation
// - every channel owns an eight-byte register window in i/o space
// - channel zero sits at base plus 000h, channel one at base plus 008h
// - offsets 00h to 07h inside a window pick the channel register
// - enable bit 0 gates the received-data-ready interrupt, reset 0
// - enable bit 1 gates the transmit-holding-empty interrupt, reset 0
// - enable bit 2 gates the receive line status interrupt, reset 0
// - enable bit 3 gates the modem status interrupt, reset 0
// - enable bit 4 gates the xoff or special character interrupt, reset 0
// - enable bit 5 gates the rts or dtr change interrupt, reset 0
// - enable bit 6 gates the cts or dsr change interrupt, reset 0
// - read-only status shows pending source, bit 0 low when pending, resets C1h
// - fifo control bit 0 at 02h turns fifo mode on or off while divisor access is clear
`timescale 1ns/1ps
`default_nettype none

module uiorb_regs #(
  parameter int unsigned NCH = uiorb_pkg::NUM_CHAN
) (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rstn_in,
  // i/o space access
  input  wire logic                 io_sel_in,
  input  wire logic                 io_wr_in,
  input  wire logic                 io_rd_in,
  input  wire logic [3:0]           io_addr_in,
  input  wire logic [7:0]           io_wdata_in,
  output logic      [7:0]           io_rdata_out,
  output logic                      io_rvalid_out,
  // receive side from channel cores
  input  wire logic [NCH-1:0]       rx_valid_in,
  input  wire logic [NCH*8-1:0]     rx_data_in,
  // transmit side to channel cores
  output logic      [NCH-1:0]       tx_valid_out,
  output logic      [NCH*8-1:0]     tx_data_out,
  // status levels from channel cores
  input  wire logic [NCH-1:0]       tx_empty_in,
  input  wire logic [NCH-1:0]       rx_error_in,
  input  wire logic [NCH-1:0]       rx_timeout_in,
  input  wire logic [NCH-1:0]       modem_chg_in,
  input  wire logic [NCH-1:0]       xoff_det_in,
  input  wire logic [NCH-1:0]       rts_dtr_chg_in,
  input  wire logic [NCH-1:0]       cts_dsr_chg_in,
  input  wire logic [NCH*8-1:0]     line_cond_in,
  input  wire logic [NCH*8-1:0]     modem_cond_in,
  // configuration to channel cores
  output logic      [NCH*8-1:0]     line_format_out,
  output logic      [NCH*8-1:0]     modem_control_out,
  output logic      [NCH*8-1:0]     special_function_out,
  output logic      [NCH*16-1:0]    baud_divisor_out,
  output logic      [NCH*8-1:0]     sample_clock_out,
  output logic      [NCH-1:0]       fifo_enable_out,
  output logic      [NCH*4-1:0]     fifo_trigger_out,
  output logic      [NCH-1:0]       rx_flush_out,
  output logic      [NCH-1:0]       tx_flush_out,
  // interrupt requests, one per channel
  output logic      [NCH-1:0]       irq_out
);

  // window hit: channel number is the address bit above the offset
  function automatic logic uiorb_hit(input logic [3:0] addr, input int unsigned ch);
    uiorb_hit = (addr[3] == ch[0]);
  endfunction : uiorb_hit

  // offset match used by every write and strobe decode; the read mux cases on the offset bits directly
  function automatic logic uiorb_off(input logic [3:0] addr, input logic [2:0] off);
    uiorb_off = (addr[2:0] == off);
  endfunction : uiorb_off

  logic [NCH-1:0][7:0] chan_rdata;
  logic [7:0]          rdata_ff;
  logic                rvalid_ff;

  // per-channel register window
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    logic       sel;
    logic       wr;
    logic       rd;
    logic       dlab;
    logic [7:0] ien_ff;
    logic [7:0] lfmt_ff;
    logic [7:0] mctl_ff;
    logic [7:0] sfunc_ff;
    logic [7:0] divl_ff;
    logic [7:0] divh_ff;
    logic [7:0] smpl_ff;
    logic       fen_ff;
    logic [3:0] trig_ff;
    logic       rxfl_ff;
    logic       txfl_ff;
    logic [7:0] rxhold_ff;
    logic       rxfull_ff;
    logic       ovr_ff;
    logic       txv_ff;
    logic [7:0] txd_ff;
    logic       txe_prev_ff;
    logic       txei_ff;
    logic [7:0] istat_ff;
    logic [7:0] nxt_istat;
    logic       irq_ff;
    logic       nxt_irq;
    logic [7:0] lcond;
    logic [7:0] rmux;
    logic       rd_hold;
    logic       wr_hold;
    logic       rd_istat;

    // address decode inside this channel's window
    assign sel      = io_sel_in & uiorb_hit(io_addr_in, g);
    assign wr       = sel & io_wr_in;
    assign rd       = sel & io_rd_in;
    assign dlab     = lfmt_ff[uiorb_pkg::LFMT_DLAB_BIT];
    assign rd_hold  = rd & uiorb_off(io_addr_in, uiorb_pkg::OFF_HOLD) & ~dlab;
    assign wr_hold  = wr & uiorb_off(io_addr_in, uiorb_pkg::OFF_HOLD) & ~dlab;
    assign rd_istat = rd & uiorb_off(io_addr_in, uiorb_pkg::OFF_ISTAT) & ~dlab;

    // plain read/write configuration registers
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        ien_ff   <= uiorb_pkg::RST_ZERO;
        lfmt_ff  <= uiorb_pkg::RST_LFMT;
        mctl_ff  <= uiorb_pkg::RST_ZERO;
        sfunc_ff <= uiorb_pkg::RST_ZERO;
      end else if (wr) begin
        if (uiorb_off(io_addr_in, uiorb_pkg::OFF_IEN) && !dlab) begin
          ien_ff <= io_wdata_in;
        end
        if (uiorb_off(io_addr_in, uiorb_pkg::OFF_LFMT)) begin
          lfmt_ff <= io_wdata_in;
        end
        if (uiorb_off(io_addr_in, uiorb_pkg::OFF_MCTL)) begin
          mctl_ff <= io_wdata_in;
        end
        if (uiorb_off(io_addr_in, uiorb_pkg::OFF_SFUNC)) begin
          sfunc_ff <= io_wdata_in;
        end
      end
    end

    // divisor and sample clock, only visible with divisor access set
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        divl_ff <= uiorb_pkg::RST_ZERO;
        divh_ff <= uiorb_pkg::RST_ZERO;
        smpl_ff <= uiorb_pkg::RST_ZERO;
      end else if (wr && dlab) begin
        if (uiorb_off(io_addr_in, uiorb_pkg::OFF_HOLD)) begin
          divl_ff <= io_wdata_in;
        end
        if (uiorb_off(io_addr_in, uiorb_pkg::OFF_IEN)) begin
          divh_ff <= io_wdata_in;
        end
        if (uiorb_off(io_addr_in, uiorb_pkg::OFF_ISTAT)) begin
          smpl_ff <= io_wdata_in;
        end
      end
    end

    // fifo control: mode bit and trigger held, flush bits pulse once
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        fen_ff  <= 1'b0;
        trig_ff <= 4'h0;
        rxfl_ff <= 1'b0;
        txfl_ff <= 1'b0;
      end else begin
        rxfl_ff <= 1'b0;
        txfl_ff <= 1'b0;
        if (wr && !dlab && uiorb_off(io_addr_in, uiorb_pkg::OFF_ISTAT)) begin
          fen_ff  <= io_wdata_in[uiorb_pkg::FCTL_EN_BIT];
          trig_ff <= io_wdata_in[uiorb_pkg::FCTL_TRIG_LSB +: 4];
          rxfl_ff <= io_wdata_in[uiorb_pkg::FCTL_RXFL_BIT];
          txfl_ff <= io_wdata_in[uiorb_pkg::FCTL_TXFL_BIT];
        end
      end
    end

    // receive holding: new byte sets full, a read empties it;
    // a byte that lands while full overwrites, and marks overrun unless the holding register is read that cycle
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        rxhold_ff <= uiorb_pkg::RST_ZERO;
        rxfull_ff <= 1'b0;
        ovr_ff    <= 1'b0;
      end else begin
        if (rx_valid_in[g]) begin
          rxhold_ff <= rx_data_in[g*8 +: 8];
          rxfull_ff <= 1'b1;                                  // set wins over the read
        end else if (rd_hold) begin
          rxfull_ff <= 1'b0;
        end
        if (rx_valid_in[g] && rxfull_ff && !rd_hold) begin
          ovr_ff <= 1'b1;
        end else if (rd && uiorb_off(io_addr_in, uiorb_pkg::OFF_LCOND)) begin
          ovr_ff <= 1'b0;
        end
      end
    end

    // transmit holding: a write hands one byte to the core for a cycle
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        txv_ff <= 1'b0;
        txd_ff <= uiorb_pkg::RST_ZERO;
      end else begin
        txv_ff <= wr_hold;
        if (wr_hold) begin
          txd_ff <= io_wdata_in;
        end
      end
    end

    // tx empty event: armed on the empty edge or on enabling while empty,
    // disarmed by a holding write or by reading it from status
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        txe_prev_ff <= 1'b1;                                  // line idles empty, no false edge
        txei_ff     <= 1'b0;
      end else begin
        txe_prev_ff <= tx_empty_in[g];
        if ((tx_empty_in[g] && !txe_prev_ff) ||
            (wr && !dlab && uiorb_off(io_addr_in, uiorb_pkg::OFF_IEN) &&
             io_wdata_in[uiorb_pkg::IEN_TXEMP_BIT] && tx_empty_in[g])) begin
          txei_ff <= 1'b1;                                    // set wins over the clear
        end else if (wr_hold || (rd_istat && istat_ff == uiorb_pkg::IST_TXEMP)) begin
          txei_ff <= 1'b0;
        end
      end
    end

    // priority encoder over enabled pending sources
    always_comb begin
      nxt_istat = uiorb_pkg::IST_NONE;
      nxt_irq   = 1'b1;
      if (rx_error_in[g] && ien_ff[uiorb_pkg::IEN_RXLINE_BIT]) begin
        nxt_istat = uiorb_pkg::IST_RXERR;
      end else if (rxfull_ff && ien_ff[uiorb_pkg::IEN_RXDATA_BIT]) begin
        nxt_istat = uiorb_pkg::IST_RXDATA;
      end else if (rx_timeout_in[g] && ien_ff[uiorb_pkg::IEN_RXDATA_BIT]) begin
        nxt_istat = uiorb_pkg::IST_RXTMO;
      end else if (txei_ff && ien_ff[uiorb_pkg::IEN_TXEMP_BIT]) begin
        nxt_istat = uiorb_pkg::IST_TXEMP;
      end else if (modem_chg_in[g] && ien_ff[uiorb_pkg::IEN_MODEM_BIT]) begin
        nxt_istat = uiorb_pkg::IST_MODEM;
      end else if (xoff_det_in[g] && ien_ff[uiorb_pkg::IEN_XOFF_BIT]) begin
        nxt_istat = uiorb_pkg::IST_XOFF;
      end else if ((rts_dtr_chg_in[g] && ien_ff[uiorb_pkg::IEN_RTSDTR_BIT]) ||
                   (cts_dsr_chg_in[g] && ien_ff[uiorb_pkg::IEN_CTSDSR_BIT])) begin
        nxt_istat = uiorb_pkg::IST_HSCHG;
      end else begin
        nxt_irq = 1'b0;
      end
    end

    // status and request registered from the encoder
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        istat_ff <= uiorb_pkg::RST_ISTAT;
        irq_ff   <= 1'b0;
      end else begin
        istat_ff <= nxt_istat;
        irq_ff   <= nxt_irq;
      end
    end

    // line condition: core bits with ready, overrun and tx empty local
    always_comb begin
      lcond                            = line_cond_in[g*8 +: 8];
      lcond[uiorb_pkg::LCOND_RDY_BIT]  = rxfull_ff;
      lcond[uiorb_pkg::LCOND_OVR_BIT]  = ovr_ff;
      lcond[uiorb_pkg::LCOND_TXE_BIT]  = tx_empty_in[g];
    end

    // read mux, remapped low offsets under divisor access
    always_comb begin
      rmux = uiorb_pkg::RST_ZERO;
      unique case (io_addr_in[2:0])
        uiorb_pkg::OFF_HOLD:  rmux = dlab ? divl_ff : rxhold_ff;
        uiorb_pkg::OFF_IEN:   rmux = dlab ? divh_ff : ien_ff;
        uiorb_pkg::OFF_ISTAT: rmux = dlab ? smpl_ff : istat_ff;
        uiorb_pkg::OFF_LFMT:  rmux = lfmt_ff;
        uiorb_pkg::OFF_MCTL:  rmux = mctl_ff;
        uiorb_pkg::OFF_LCOND: rmux = lcond;
        uiorb_pkg::OFF_MCOND: rmux = modem_cond_in[g*8 +: 8];
        uiorb_pkg::OFF_SFUNC: rmux = sfunc_ff;
      endcase
    end

    // per-channel outputs from flip-flops, except the combinational read mux data
    assign chan_rdata[g]                 = rmux;
    assign tx_valid_out[g]               = txv_ff;
    assign tx_data_out[g*8 +: 8]         = txd_ff;
    assign line_format_out[g*8 +: 8]     = lfmt_ff;
    assign modem_control_out[g*8 +: 8]   = mctl_ff;
    assign special_function_out[g*8 +: 8] = sfunc_ff;
    assign baud_divisor_out[g*16 +: 16]  = {divh_ff, divl_ff};
    assign sample_clock_out[g*8 +: 8]    = smpl_ff;
    assign fifo_enable_out[g]            = fen_ff;
    assign fifo_trigger_out[g*4 +: 4]    = trig_ff;
    assign rx_flush_out[g]               = rxfl_ff;
    assign tx_flush_out[g]               = txfl_ff;
    assign irq_out[g]                    = irq_ff;
  end

  // read data returned one cycle after the strobe
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_ff  <= uiorb_pkg::RST_ZERO;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= io_sel_in & io_rd_in;
      if (io_sel_in && io_rd_in) begin
        rdata_ff <= chan_rdata[io_addr_in[3]];
      end
    end
  end

  assign io_rdata_out  = rdata_ff;
  assign io_rvalid_out = rvalid_ff;

endmodule : uiorb_regs

`default_nettype wire

// *** core/uiorb_pkg.sv ***
// package of the two-channel uart register front end
// assumes: shared by the core file only, nothing is imported
package uiorb_pkg;

  // channel layout: each channel owns an eight-byte window
  localparam int unsigned NUM_CHAN    = 2;
  localparam int unsigned WIN_BYTES   = 8;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned OFF_W       = 3;
  localparam int unsigned DATA_W      = 8;

  // window bases above the first base address register
  localparam logic [ADDR_W-1:0] CHAN0_BASE = 4'h0;
  localparam logic [ADDR_W-1:0] CHAN1_BASE = 4'h8;

  // register offsets inside a channel window
  localparam logic [OFF_W-1:0] OFF_HOLD   = 3'h0;
  localparam logic [OFF_W-1:0] OFF_IEN    = 3'h1;
  localparam logic [OFF_W-1:0] OFF_ISTAT  = 3'h2;
  localparam logic [OFF_W-1:0] OFF_LFMT   = 3'h3;
  localparam logic [OFF_W-1:0] OFF_MCTL   = 3'h4;
  localparam logic [OFF_W-1:0] OFF_LCOND  = 3'h5;
  localparam logic [OFF_W-1:0] OFF_MCOND  = 3'h6;
  localparam logic [OFF_W-1:0] OFF_SFUNC  = 3'h7;

  // field positions
  localparam int unsigned LFMT_DLAB_BIT  = 7;
  localparam int unsigned IEN_RXDATA_BIT = 0;
  localparam int unsigned IEN_TXEMP_BIT  = 1;
  localparam int unsigned IEN_RXLINE_BIT = 2;
  localparam int unsigned IEN_MODEM_BIT  = 3;
  localparam int unsigned IEN_XOFF_BIT   = 4;
  localparam int unsigned IEN_RTSDTR_BIT = 5;
  localparam int unsigned IEN_CTSDSR_BIT = 6;
  localparam int unsigned FCTL_EN_BIT    = 0;
  localparam int unsigned FCTL_RXFL_BIT  = 1;
  localparam int unsigned FCTL_TXFL_BIT  = 2;
  localparam int unsigned FCTL_TRIG_LSB  = 4;
  localparam int unsigned LCOND_RDY_BIT  = 0;
  localparam int unsigned LCOND_OVR_BIT  = 1;
  localparam int unsigned LCOND_TXE_BIT  = 5;

  // reset values
  localparam logic [DATA_W-1:0] RST_ZERO  = 8'h00;
  localparam logic [DATA_W-1:0] RST_LFMT  = 8'h03;
  localparam logic [DATA_W-1:0] RST_ISTAT = 8'hC1;

  // interrupt status codes, highest priority first
  localparam logic [DATA_W-1:0] IST_RXERR  = 8'hC6;
  localparam logic [DATA_W-1:0] IST_RXDATA = 8'hC4;
  localparam logic [DATA_W-1:0] IST_RXTMO  = 8'hCC;
  localparam logic [DATA_W-1:0] IST_TXEMP  = 8'hC2;
  localparam logic [DATA_W-1:0] IST_MODEM  = 8'hC0;
  localparam logic [DATA_W-1:0] IST_XOFF   = 8'hD0;
  localparam logic [DATA_W-1:0] IST_HSCHG  = 8'hE0;
  localparam logic [DATA_W-1:0] IST_NONE   = 8'hC1;

endpackage : uiorb_pkg

// *** dv/uiorb_far_model.sv ***
// far-side serial device model: echoes each transmitted byte back, a newer byte replacing one still in flight
// assumes: shares the register block clock, two channels
`timescale 1ns/1ps
`default_nettype none
module uiorb_far_model (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // bytes from the block, echo pace
  input  wire logic [1:0]  tx_valid_in,
  input  wire logic [15:0] tx_data_in,
  input  wire logic        slow_in,
  // echoed bytes and idle status
  output logic      [1:0]  rx_valid_out,
  output logic      [15:0] rx_data_out,
  output logic      [1:0]  tx_empty_out
);
  logic [5:0] cnt_ff [2];
  logic [7:0] byte_ff [2];
  logic [1:0] busy_ff;
  // byte spends a short or long line time away, then returns
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_ff      <= 2'h0;
      rx_valid_out <= 2'h0;
      rx_data_out  <= 16'h0000;
    end else begin
      for (int g = 0; g < 2; g++) begin
        rx_valid_out[g] <= 1'b0;
        rx_data_out[g*8+:8] <= ~rx_data_out[g*8+:8]; // idle data never holds
        if (tx_valid_in[g]) begin
          byte_ff[g] <= tx_data_in[g*8+:8];
          cnt_ff[g]  <= slow_in ? 6'h28 : 6'h03;
          busy_ff[g] <= 1'b1;
        end else if (busy_ff[g] && cnt_ff[g] != 6'h00) begin
          cnt_ff[g] <= cnt_ff[g] - 6'h01;
        end else if (busy_ff[g]) begin
          busy_ff[g]          <= 1'b0;
          rx_valid_out[g]     <= 1'b1;
          rx_data_out[g*8+:8] <= byte_ff[g];
        end
      end
    end
  end
  // line idle while nothing is in flight
  assign tx_empty_out = ~busy_ff;
endmodule : uiorb_far_model
`default_nettype wire

// *** dv/uiorb_regs_chk.sv ***
// port assertions of the register block
// assumes: bound into uiorb_regs, at least two channels
`timescale 1ns/1ps
`default_nettype none
module uiorb_regs_chk #(
  parameter int unsigned NCH = 2
) (
  // clock, reset, i/o access
  input wire logic              clk_in,
  input wire logic              rstn_in,
  input wire logic              io_sel_in,
  input wire logic              io_wr_in,
  input wire logic              io_rd_in,
  input wire logic [3:0]        io_addr_in,
  input wire logic [7:0]        io_wdata_in,
  input wire logic              io_rvalid_out,
  // channel side
  input wire logic [NCH-1:0]    rx_valid_in,
  input wire logic [NCH-1:0]    tx_valid_out,
  input wire logic [NCH*8-1:0]  tx_data_out,
  input wire logic [NCH*8-1:0]  line_format_out,
  input wire logic [NCH*16-1:0] baud_divisor_out,
  input wire logic [NCH*8-1:0]  sample_clock_out,
  input wire logic [NCH-1:0]    fifo_enable_out,
  input wire logic [NCH*4-1:0]  fifo_trigger_out,
  input wire logic [NCH-1:0]    rx_flush_out,
  input wire logic [NCH-1:0]    tx_flush_out,
  input wire logic [NCH-1:0]    irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  logic       wr;
  logic [7:0] ien0_ff;
  assign wr = io_sel_in && io_wr_in;
  // shadow of channel zero enables
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ien0_ff <= 8'h00;
    end else if (wr && io_addr_in == 4'h1 && !line_format_out[7]) begin
      ien0_ff <= io_wdata_in;
    end
  end
  // byte arrives and data-ready stays enabled a cycle
  sequence s_rx_armed;
    rx_valid_in[0] && ien0_ff[0] ##1 ien0_ff[0];
  endsequence
  chk_read_answer: assert property (io_sel_in && io_rd_in |=> io_rvalid_out)
    else $error("read answer missing");
  chk_tx_hold_ch0: assert property (wr && io_addr_in == 4'h0 && !line_format_out[7] |=>
    tx_valid_out[1:0] == 2'h1 && tx_data_out[7:0] == $past(io_wdata_in))
    else $error("channel zero send wrong");
  chk_tx_hold_ch1: assert property (wr && io_addr_in == 4'h8 && !line_format_out[15] |=>
    tx_valid_out[1:0] == 2'h2 && tx_data_out[15:8] == $past(io_wdata_in))
    else $error("channel one send wrong");
  chk_divisor_low: assert property (wr && io_addr_in == 4'h0 && line_format_out[7] |=>
    !tx_valid_out[0] && baud_divisor_out[7:0] == $past(io_wdata_in))
    else $error("divisor low write wrong");
  chk_fifo_mode: assert property (wr && io_addr_in == 4'h2 && !line_format_out[7] |=>
    fifo_enable_out[0] == $past(io_wdata_in[0]))
    else $error("fifo mode not updated");
  chk_flush_pulse: assert property (wr && io_addr_in == 4'h2 && !line_format_out[7] |=>
    rx_flush_out[0] == $past(io_wdata_in[1]) && tx_flush_out[0] == $past(io_wdata_in[2]) &&
    fifo_trigger_out[3:0] == $past(io_wdata_in[7:4]))
    else $error("fifo control side fields wrong");
  chk_sample_clk: assert property (wr && io_addr_in == 4'h2 && line_format_out[7] |=>
    sample_clock_out[7:0] == $past(io_wdata_in) && $stable(fifo_enable_out[0]))
    else $error("sample clock write wrong");
  chk_irq_masked: assert property (ien0_ff[6:0] == 7'h00 && !wr |=> !irq_out[0])
    else $error("request with all enables off");
  chk_rx_irq: assert property (s_rx_armed |=> irq_out[0])
    else $error("data-ready request missing");
endmodule : uiorb_regs_chk
bind uiorb_regs uiorb_regs_chk #(.NCH(NCH)) u_chk (.clk_in, .rstn_in, .io_sel_in,
  .io_wr_in, .io_rd_in, .io_addr_in, .io_wdata_in, .io_rvalid_out, .rx_valid_in,
  .tx_valid_out, .tx_data_out, .line_format_out, .baud_divisor_out, .sample_clock_out,
  .fifo_enable_out, .fifo_trigger_out, .rx_flush_out, .tx_flush_out, .irq_out);
`default_nettype wire

// *** dv/uiorb_regs_tb_top.sv ***
// self-checking bench of the register block with an echoing far side
// assumes: checker bound in its own file, two channels
`timescale 1ns/1ps
`default_nettype none
module uiorb_regs_tb_top;
  logic        clk_in = 1'b0, rstn_in = 1'b0, slow_in = 1'b0, io_rvalid_out;
  logic        io_sel_in = 1'b0, io_wr_in = 1'b0, io_rd_in = 1'b0;
  logic [3:0]  io_addr_in = 4'h0;
  logic [7:0]  io_wdata_in = 8'h00, io_rdata_out;
  logic [1:0]  rx_valid_in, tx_valid_out, tx_empty_in, irq_out, fifo_enable_out;
  logic [1:0]  src [6] = '{default: 2'h0};
  logic [15:0] rx_data_in, tx_data_out, line_cond_in = 16'h0000, modem_cond_in = 16'h0000;
  logic [31:0] baud_divisor_out, seed = 32'h783A;
  logic [15:0] modem_control_out, special_function_out;
  int          n_errors = 0, n_checks = 0;
  // 50 MHz clock
  always #10 clk_in = ~clk_in;
  uiorb_regs DUT (.clk_in, .rstn_in, .io_sel_in, .io_wr_in, .io_rd_in, .io_addr_in,
    .io_wdata_in, .io_rdata_out, .io_rvalid_out, .rx_valid_in, .rx_data_in,
    .tx_valid_out, .tx_data_out, .tx_empty_in, .rx_error_in(src[0]),
    .rx_timeout_in(src[1]), .modem_chg_in(src[2]), .xoff_det_in(src[3]),
    .rts_dtr_chg_in(src[4]), .cts_dsr_chg_in(src[5]), .line_cond_in, .modem_cond_in,
    .line_format_out(), .modem_control_out, .special_function_out,
    .baud_divisor_out, .sample_clock_out(), .fifo_enable_out, .fifo_trigger_out(),
    .rx_flush_out(), .tx_flush_out(), .irq_out);
  uiorb_far_model u_far (.clk_in, .rstn_in, .tx_valid_in(tx_valid_out),
    .tx_data_in(tx_data_out), .slow_in, .rx_valid_out(rx_valid_in),
    .rx_data_out(rx_data_in), .tx_empty_out(tx_empty_in));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // status code expected from enables and level sources
  function automatic logic [7:0] exp_status(input logic [7:0] en, input logic [5:0] s);
    if (s[0] && en[2]) return 8'hC6;
    if (s[1] && en[0]) return 8'hCC;
    if (s[2] && en[3]) return 8'hC0;
    if (s[3] && en[4]) return 8'hD0;
    if ((s[4] && en[5]) || (s[5] && en[6])) return 8'hE0;
    return 8'hC1;
  endfunction : exp_status
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    io_sel_in   <= 1'b1;
    io_wr_in    <= 1'b1;
    io_addr_in  <= a;
    io_wdata_in <= d;
    @(posedge clk_in);
    io_sel_in <= 1'b0;
    io_wr_in  <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    io_sel_in  <= 1'b1;
    io_rd_in   <= 1'b1;
    io_addr_in <= a;
    @(posedge clk_in);
    io_sel_in <= 1'b0;
    io_rd_in  <= 1'b0;
    #1;
    check({15'h0000, io_rvalid_out}, 16'h0001);
    check({8'h00, io_rdata_out}, {8'h00, e});
  endtask : rdc
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  // watchdog well beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    end_sim();
  end
  // main sequence
  initial begin
    int unsigned c, k;
    logic [3:0]  b;
    logic [5:0]  s;
    logic [7:0]  en, d0, d1, mem [4];
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    for (c = 0; c < 2; c++) begin
      b = {c[0], 3'h0};
      rdc(b | 4'h2, 8'hC1);
      rdc(b | 4'h1, 8'h00);
      rdc(b | 4'h3, 8'h03);
    end
    // tx-empty enabled on an idle line: one event, cleared by the read
    wr(4'h9, 8'h02);
    rdc(4'h2, 8'hC1);
    check({14'h0000, irq_out}, 16'h0002);
    rdc(4'hA, 8'hC2);
    rdc(4'hA, 8'hC1);
    // one-hot sources first, then random mixes of sources and enables
    for (k = 0; k < 36; k++) begin
      c  = xs() & 32'h1;
      b  = {c[0], 3'h0};
      s  = (k < 6) ? 6'h01 << k : 6'(xs());
      en = (k < 6) ? 8'h7D : 8'(xs()) & 8'h7D;
      @(posedge clk_in);
      for (int i = 0; i < 6; i++) src[i][c] <= s[i];
      wr(b | 4'h1, en);
      rdc(b | 4'h1, en);
      rdc(b | 4'h2, exp_status(en, s));
      check({15'h0000, irq_out[c]}, {15'h0000, exp_status(en, s) != 8'hC1});
    end
    @(posedge clk_in);
    for (int i = 0; i < 6; i++) src[i] <= 2'h0;
    // echoed bytes: prompt with data-ready on, slow with enables off
    for (k = 0; k < 4; k++) begin
      c  = k & 32'h1;
      b  = {c[0], 3'h0};
      en = (k < 2) ? 8'h01 : 8'h00;
      d0 = 8'(xs());
      @(posedge clk_in);
      slow_in <= k[1];
      wr(b | 4'h1, en);
      wr(b, d0);
      for (int t = 0; t < 100 && !rx_valid_in[c]; t++) begin
        @(posedge clk_in);
        #1;
      end
      repeat (2) @(posedge clk_in);
      #1;
      check({15'h0000, irq_out[c]}, {15'h0000, en[0]});
      rdc(b | 4'h2, en[0] ? 8'hC4 : 8'hC1);
      // line condition: byte ready, transmitter idle again
      rdc(b | 4'h5, 8'h21);
      rdc(b, d0);
    end
    // divisor access remaps the low offsets; fifo mode follows bit 0
    for (c = 0; c < 2; c++) begin
      b  = {c[0], 3'h0};
      d0 = 8'(xs());
      d1 = 8'(xs());
      en = 8'(xs());
      wr(b | 4'h3, 8'h83);
      wr(b, d0);
      wr(b | 4'h1, d1);
      wr(b | 4'h2, en);
      rdc(b, d0);
      rdc(b | 4'h2, en);
      check(baud_divisor_out[c*16+:16], {d1, d0});
      wr(b | 4'h3, 8'h03);
      rdc(b | 4'h1, 8'h00);
      for (k = 0; k < 2; k++) begin
        wr(b | 4'h2, {d1[7:1], 1'(k ^ 1)});
        #1;
        check({15'h0000, fifo_enable_out[c]}, 16'(k ^ 1));
      end
    end
    // registers of one window never leak into the other
    for (k = 0; k < 8; k++) begin
      b = {k[1], k[0] ? 3'h7 : 3'h4};
      if (k < 4) begin
        mem[k] = 8'(xs());
        wr(b, mem[k]);
        #1;
        d0 = 8'((k[0] ? special_function_out : modem_control_out) >> {k[1], 3'h0});
        check({8'h00, d0}, {8'h00, mem[k]});
      end else begin
        rdc(b, mem[k-4]);
      end
    end
    end_sim();
  end
endmodule : uiorb_regs_tb_top
`default_nettype wire
